// ==== hw/capture_timer_pkg.sv ====
// Package: register map, field layout and types of the capture/compare timer
// Overview of operation
// - Read-only capture high byte holds count bits 15..8; undefined after reset.
// - Four capture inputs: three filtered Hall signals and one external pin.
// - Each input edge detection: rising, falling or both, by two-bit field.
// - Module-on bit enables timer; off stops the counter.
// - Capture input enable bit gates capture recognition independently.
// - Filter enable bit switches a glitch filter on Hall inputs.
// - Filter accepts a level after 2 or 4 identical samples, bit selects.
// - Filter samples at system clock or system clock divided by four.
// - Valid edge with capture enabled copies 16-bit count into capture bytes.
// - Counter overflow sets the overflow interrupt flag.
// - Capture auto-clear resets counter to zero after the count is stored.
// - Software-written 16-bit compare value held in two byte registers.
// - Counter equal to compare value sets the compare match flag.
// - Match auto-clear resets counter to zero on compare match.
// - Three-bit counter clock select: PWM period signal, or sysclk/2..128.
// - Module-on rising clears counter; falling keeps residual value.
// - Pause bit freezes counter; counting resumes from held value.
// - Edge field: 00 off, 01 rising, 10 falling, 11 both edges.
package capture_timer_pkg;

  // Register byte addresses (word aligned)
  localparam logic [7:0] ctrl0_addr                   = 8'h00;
  localparam logic [7:0] ctrl1_addr                   = 8'h04;
  localparam logic [7:0] counter_low_byte_addr        = 8'h08;
  localparam logic [7:0] counter_high_byte_addr       = 8'h0C;
  localparam logic [7:0] compare_value_low_byte_addr  = 8'h10;
  localparam logic [7:0] compare_value_high_byte_addr = 8'h14;
  localparam logic [7:0] capture_value_low_byte_addr  = 8'h18;
  localparam logic [7:0] capture_value_high_byte_addr = 8'h1C;
  localparam logic [7:0] irq_status_addr              = 8'h20;
  localparam logic [7:0] irq_mask_addr                = 8'h24;

  // Control register 0 fields
  localparam int pause_pos  = 7;
  localparam int clksel_lsb = 4;
  localparam int module_pos = 3;
  localparam int srcsel_lsb = 0;
  // Control register 1 fields
  localparam int edge_lsb     = 6;
  localparam int capture_input_enable_pos    = 5;
  localparam int nft_pos      = 4;
  localparam int nfs_pos      = 3;
  localparam int fil_pos      = 2;
  localparam int capture_auto_clear_pos   = 1;
  localparam int matchclr_pos = 0;
  // Interrupt status / mask bits
  localparam int ovf_bit   = 0;
  localparam int match_bit = 1;
  localparam int cap_bit   = 2;

  localparam logic [7:0] ctrl_reset  = 8'h00;
  localparam logic [2:0] irq_reset   = 3'h0;
  localparam logic [2:0] filt_div    = 3'h4;
  localparam logic [2:0] short_count = 3'h2;
  localparam logic [2:0] long_count  = 3'h4;

  // Edge select encodings
  typedef enum logic [1:0] {
    edge_off  = 2'h0,
    edge_rise = 2'h1,
    edge_fall = 2'h2,
    edge_both = 2'h3
  } edge_e;

  // Timer configuration bundle
  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       module_on;
    logic [1:0] src_sel;
    edge_e      edge_sel;
    logic       cap_en;
    logic       filt_long;
    logic       filt_slow;
    logic       filt_en;
    logic       cap_clr;
    logic       match_clr;
  } timer_cfg_s;

endpackage

// ==== hw/glitch_filter.sv ====
// Glitch filter: accepts a level after N identical samples
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
  import capture_timer_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic sample_tick,
  input  wire logic long_count_sel,
  input  wire logic din,
  output var  logic dout
);

  logic [2:0] run;

  ////////////////////////////////////////////////////////////////////////
  // Consecutive sample check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run  <= 3'h0;
      dout <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        run  <= 3'h0;
        dout <= din; // Bypass when filter off
      end else if (sample_tick) begin
        if (din == dout) begin
          run <= 3'h0;
        end else if (run + 3'h1 >= (long_count_sel ? long_count : short_count)) begin
          run  <= 3'h0;
          dout <= din;
        end else begin
          run <= run + 3'h1;
        end
      end
    end
  end

endmodule // glitch_filter
`default_nettype wire

// ==== hw/edge_detect.sv ====
// Edge detector with rise/fall/both selection
`timescale 1ns/1ps
`default_nettype none
module edge_detect
  import capture_timer_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  ce,
  input  wire edge_e edge_sel,
  input  wire logic  din,
  output var  logic  hit
);

  logic prev;

  // Previous level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= din;
    end
  end

  always_comb begin
    case (edge_sel)
      edge_rise: hit = din & ~prev;
      edge_fall: hit = ~din & prev;
      edge_both: hit = din ^ prev;
      default:   hit = 1'b0;
    endcase
  end

endmodule // edge_detect
`default_nettype wire

// ==== hw/capture_timer_unit.sv ====
// Capture/compare timer with APB register interface
`timescale 1ns/1ps
`default_nettype none
module capture_timer_unit
  import capture_timer_pkg::*;
#(
  parameter int count_width = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        hall_pin_one,
  input  wire logic        hall_pin_two,
  input  wire logic        hall_pin_three,
  input  wire logic        external_capture_pin,
  input  wire logic        pwm_period_signal,
  output var  logic        irq
);

  // Counter width must fit the 16-bit register pair
  if (count_width < 2 || count_width > 16) begin : g_width_check
    $error("count_width must lie between 2 and 16");
  end

  // Top count before the counter wraps to zero
  localparam logic [15:0] count_max = 16'((17'h1 << count_width) - 17'h1);

  timer_cfg_s  cfg;
  logic [15:0] counter;
  logic [15:0] compare_value;
  logic [15:0] capture_value;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [3:0]  pin_meta;
  logic [3:0]  pin_sync;
  logic        pwm_meta;
  logic        pwm_sync;
  logic        pwm_prev;
  logic [2:0]  hall_filt;
  logic [1:0]  filt_div_cnt;
  logic        filt_tick;
  logic [6:0]  prescale;
  logic [6:0]  next_prescale;
  logic        count_tick;
  logic        module_prev;
  logic        sel_in;
  logic        edge_hit;
  logic        capture_event;
  logic        match_event;
  logic        ovf_event;
  logic        wr;
  logic        rd;
  logic [2:0]  clr_bits;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pwm_meta <= 1'b0;
      pwm_sync <= 1'b0;
      pwm_prev <= 1'b0;
    end else if (ce) begin
      pin_meta <= {external_capture_pin, hall_pin_three, hall_pin_two, hall_pin_one};
      pin_sync <= pin_meta;
      pwm_meta <= pwm_period_signal;
      pwm_sync <= pwm_meta;
      pwm_prev <= pwm_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Filter sample rate divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_div_cnt <= 2'h0;
    end else if (ce) begin
      filt_div_cnt <= filt_div_cnt + 2'h1;
    end
  end
  assign filt_tick = cfg.filt_slow ? (filt_div_cnt == 2'(filt_div - 3'h1)) : 1'b1;

  // Hall input filters, active with module on
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_hall
      glitch_filter u_filt (
        .pclk           (pclk),
        .presetn        (presetn),
        .ce             (ce),
        .enable         (cfg.filt_en & cfg.module_on),
        .sample_tick    (filt_tick),
        .long_count_sel (cfg.filt_long),
        .din            (pin_sync[g]),
        .dout           (hall_filt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Capture source mux
  always_comb begin
    case (cfg.src_sel)
      2'h0:    sel_in = hall_filt[0];
      2'h1:    sel_in = hall_filt[1];
      2'h2:    sel_in = hall_filt[2];
      default: sel_in = pin_sync[3];
    endcase
  end

  edge_detect u_edge (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .edge_sel (cfg.edge_sel),
    .din      (sel_in),
    .hit      (edge_hit)
  );

  // Capture gated by enable and module on
  assign capture_event = edge_hit & cfg.cap_en & cfg.module_on;

  ////////////////////////////////////////////////////////////////////////
  // Counter clock prescaler
  assign next_prescale = prescale + 7'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 7'h0;
    end else if (ce) begin
      prescale <= next_prescale;
    end
  end

  always_comb begin
    case (cfg.clk_sel)
      3'h0:    count_tick = pwm_sync & ~pwm_prev;
      default: count_tick = (prescale & ((7'h1 << cfg.clk_sel) - 7'h1)) == 7'h0;
    endcase
  end

  assign match_event = cfg.module_on & (counter == compare_value);
  assign ovf_event   = cfg.module_on & ~cfg.pause & count_tick & (counter == count_max);

  ////////////////////////////////////////////////////////////////////////
  // Counter with clear, pause and auto-reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter     <= 16'h0000;
      module_prev <= 1'b0;
    end else if (ce) begin
      module_prev <= cfg.module_on;
      if (cfg.module_on & ~module_prev) begin
        counter <= 16'h0000;
      end else if (capture_event & cfg.cap_clr) begin
        counter <= 16'h0000;
      end else if (match_event & cfg.match_clr & (counter != 16'h0000)) begin
        counter <= 16'h0000;
      // Count only while on and not paused
      end else if (cfg.module_on & ~cfg.pause & count_tick) begin
        counter <= (counter == count_max) ? 16'h0000 : counter + 16'h0001; // Wrap at width top
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture register, no reset value
  always_ff @(posedge pclk) begin
    if (ce & capture_event) begin
      capture_value <= counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode, zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel & penable & pwrite & ce;
  assign rd      = psel & ~pwrite;

  // Control and compare registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg           <= '0;
      compare_value <= 16'h0000;
      irq_mask      <= irq_reset;
    end else if (wr) begin
      case (paddr)
        ctrl0_addr: begin
          cfg.pause     <= pwdata[pause_pos];
          cfg.clk_sel   <= pwdata[clksel_lsb +: 3];
          cfg.module_on <= pwdata[module_pos];
          cfg.src_sel   <= pwdata[srcsel_lsb +: 2];
        end
        ctrl1_addr: begin
          cfg.edge_sel  <= edge_e'(pwdata[edge_lsb +: 2]);
          cfg.cap_en    <= pwdata[capture_input_enable_pos];
          cfg.filt_long <= pwdata[nft_pos];
          cfg.filt_slow <= pwdata[nfs_pos];
          cfg.filt_en   <= pwdata[fil_pos];
          cfg.cap_clr   <= pwdata[capture_auto_clear_pos];
          cfg.match_clr <= pwdata[matchclr_pos];
        end
        compare_value_low_byte_addr:  compare_value[7:0]  <= pwdata[7:0];
        compare_value_high_byte_addr: compare_value[15:8] <= pwdata[7:0];
        irq_mask_addr:                irq_mask <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over write-one clear
  assign clr_bits = (wr && paddr == irq_status_addr) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= irq_reset;
    end else if (ce) begin
      irq_status <= (irq_status & ~clr_bits)
                  | {capture_event, match_event, ovf_event};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        ctrl0_addr:   prdata[7:0] = {cfg.pause, cfg.clk_sel, cfg.module_on, 1'b0, cfg.src_sel};
        ctrl1_addr:   prdata[7:0] = {cfg.edge_sel, cfg.cap_en, cfg.filt_long, cfg.filt_slow,
                                     cfg.filt_en, cfg.cap_clr, cfg.match_clr};
        counter_low_byte_addr:        prdata[7:0] = counter[7:0];
        counter_high_byte_addr:       prdata[7:0] = counter[15:8];
        compare_value_low_byte_addr:  prdata[7:0] = compare_value[7:0];
        compare_value_high_byte_addr: prdata[7:0] = compare_value[15:8];
        capture_value_low_byte_addr:  prdata[7:0] = capture_value[7:0];
        capture_value_high_byte_addr: prdata[7:0] = capture_value[15:8];
        irq_status_addr:              prdata[2:0] = irq_status;
        irq_mask_addr:                prdata[2:0] = irq_mask;
        default:                      prdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // Enable rising clears counter
  on_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.module_on && !module_prev |=> counter == 16'h0000)
    else $error("counter not cleared on enable");
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.pause && module_prev && !capture_event && !match_event |=> $stable(counter))
    else $error("counter moved while paused");
  off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg.module_on && !module_prev |=> $stable(counter))
    else $error("counter moved while off");
  cap_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && capture_event |=> capture_value == $past(counter))
    else $error("capture value wrong");
  cap_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && capture_event && cfg.cap_clr |=> counter == 16'h0000)
    else $error("counter not cleared after capture");
  match_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && match_event |=> irq_status[match_bit])
    else $error("match flag not set");
  ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ovf_event && module_prev && !capture_event |=> irq_status[ovf_bit])
    else $error("overflow flag not set");
  cap_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg.cap_en && !irq_status[cap_bit] |=> !irq_status[cap_bit])
    else $error("capture without enable");
  match_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && match_event && cfg.match_clr && module_prev && counter != 16'h0000
    |=> counter == 16'h0000)
    else $error("counter not cleared on match");

  ////////////////////////////////////////////////////////////////////////
  // Checks on wrap, tick spacing, filters and registers
  // Overflow wraps to zero
  ovf_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ovf_event && module_prev && !capture_event && !cfg.match_clr |=> counter == 16'h0000)
    else $error("counter did not wrap on overflow");
  ovf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == irq_status_addr && pwdata[ovf_bit] && !ovf_event |=> !irq_status[ovf_bit])
    else $error("overflow flag not cleared");
  // Prescaled ticks never back to back
  tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.clk_sel != 3'h0 && count_tick |=> !count_tick || cfg.clk_sel != $past(cfg.clk_sel))
    else $error("prescaled tick repeated");
  filt_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(cfg.filt_en && cfg.module_on) |=> hall_filt == $past(pin_sync[2:0]))
    else $error("filter not bypassed");
  filt_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.filt_slow && filt_tick |=> !filt_tick || !cfg.filt_slow)
    else $error("slow filter tick repeated");
  cmp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == compare_value_low_byte_addr |=> compare_value[7:0] == $past(pwdata[7:0]))
    else $error("compare byte not written");
  edge_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.edge_sel == edge_off |-> !edge_hit)
    else $error("edge hit while detection off");
  off_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg.module_on && module_prev |=> $stable(counter))
    else $error("counter moved after switch off");

  cap_seen_c:   cover property (@(posedge pclk) disable iff (!presetn) capture_event);
  match_seen_c: cover property (@(posedge pclk) disable iff (!presetn) match_event);
  ovf_seen_c:   cover property (@(posedge pclk) disable iff (!presetn) ovf_event);
  irq_seen_c:   cover property (@(posedge pclk) disable iff (!presetn) irq);
  clr_seen_c:   cover property (@(posedge pclk) disable iff (!presetn) capture_event && cfg.cap_clr);

endmodule // capture_timer_unit
`default_nettype wire

// ==== tb/pin_model.sv ====
// Far-side model: Hall pins, external capture pin and PWM period signal
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic       pclk,
  input  wire logic [3:0] level,
  input  wire logic       pwm_run,
  output var  logic       hall_pin_one,
  output var  logic       hall_pin_two,
  output var  logic       hall_pin_three,
  output var  logic       external_capture_pin,
  output var  logic       pwm_period_signal
);
  logic [3:0] pwm_div = 4'h0;

  // Pins follow the commanded levels, one bit per capture input
  always_comb begin
    {external_capture_pin, hall_pin_three, hall_pin_two, hall_pin_one} = level;
  end

  // Period signal of 16 cycles, held low while stopped
  always_ff @(posedge pclk) begin
    pwm_div <= pwm_run ? pwm_div + 4'h1 : 4'h0;
  end
  always_comb begin
    pwm_period_signal = pwm_div[3];
  end
endmodule // pin_model
`default_nettype wire

// ==== tb/capture_compare_timer_tb.sv ====
// Self-checking testbench of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module capture_compare_timer_tb;
  import capture_timer_pkg::*;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        ce          = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        h1;
  logic        h2;
  logic        h3;
  logic        ext;
  logic        pwm;
  logic [3:0]  level       = 4'h0;
  logic        pwm_run     = 1'b0;
  int          n_fail      = 0;
  int          check_count = 0;
  int          n;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [7:0]  cmp_lo;
  logic [7:0]  cmp_hi;
  // Filter cases: flags {nft,nfs,fil}, pulse cycles, capture expected
  int ft[9][3] = '{'{0,1,1}, '{4,1,0}, '{4,4,1}, '{20,2,0}, '{20,8,1},
                   '{12,2,0}, '{12,16,1}, '{28,6,0}, '{28,32,1}};

  initial begin
    forever #5 pclk = ~pclk;
  end

  capture_timer_unit #(.count_width(12)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hall_pin_one(h1),
    .hall_pin_two(h2), .hall_pin_three(h3), .external_capture_pin(ext),
    .pwm_period_signal(pwm), .irq(irq));

  pin_model far (.pclk(pclk), .level(level), .pwm_run(pwm_run), .hall_pin_one(h1),
    .hall_pin_two(h2), .hall_pin_three(h3), .external_capture_pin(ext),
    .pwm_period_signal(pwm));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and verdict tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer: setup, access until pready, then release
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [7:0] r);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    r = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] c0(input int p, input int s, input int o, input int src);
    return 32'((p << pause_pos) | (s << clksel_lsb) | (o << module_pos) | (src << srcsel_lsb));
  endfunction

  function automatic logic [31:0] c1(input int e, input int en, input int f);
    return 32'((e << edge_lsb) | (en << capture_input_enable_pos) | f);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cmp_lo = 8'($urandom(84));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped word reads zero
    for (int i = 0; i < 11; i++) begin
      if (i != 6 && i != 7) begin
        bus(0, 8'(i * 4), 0, a);
        check(32'(a), 0);
      end
    end
    // Writes ignored with clock enable low, then random compare value
    ce <= 1'b0;
    bus(1, compare_value_low_byte_addr, 32'h5A, a);
    ce <= 1'b1;
    bus(0, compare_value_low_byte_addr, 0, a);
    check(32'(a), 0);
    cmp_lo = 8'($urandom) | 8'h01;
    cmp_hi = 8'($urandom) & 8'h0F;
    bus(1, compare_value_low_byte_addr, 32'(cmp_lo), a);
    bus(1, compare_value_high_byte_addr, 32'(cmp_hi), a);
    bus(0, compare_value_low_byte_addr, 0, a);
    check(32'(a), 32'(cmp_lo));
    bus(0, compare_value_high_byte_addr, 0, a);
    check(32'(a), 32'(cmp_hi));
    // Every clock select: four ticks over a known span
    pwm_run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      bus(1, ctrl0_addr, c0(0, s, 1, 0), a);
      bus(0, counter_low_byte_addr, 0, a);
      repeat (((s == 0) ? 64 : (4 << s)) - 3) @(posedge pclk);
      bus(0, counter_low_byte_addr, 0, b);
      check(32'(8'(b - a)), 4);
    end
    // Switch on while paused: cleared and frozen, then resume
    bus(1, ctrl0_addr, 0, a);
    bus(1, ctrl0_addr, c0(1, 1, 1, 0), a);
    repeat (40) @(posedge pclk);
    bus(0, counter_low_byte_addr, 0, a);
    check(32'(a), 0);
    bus(1, ctrl0_addr, c0(0, 1, 1, 0), a);
    repeat (37) @(posedge pclk);
    bus(0, counter_low_byte_addr, 0, a);
    check(32'(a >= 19 && a <= 21), 1);
    // Off keeps the residual value, on again clears it
    bus(1, ctrl0_addr, c0(0, 1, 0, 0), a);
    repeat (30) @(posedge pclk);
    bus(0, counter_low_byte_addr, 0, b);
    check(32'(b >= 20 && b <= 23), 1);
    bus(1, ctrl0_addr, c0(0, 7, 1, 0), a);
    bus(0, counter_low_byte_addr, 0, a);
    check(32'(a <= 1), 1);
    // Every source, edge mode and enable: others ignored, edges per mode
    for (int k = 0; k < 32; k++) begin
      bus(1, ctrl0_addr, c0(1, 1, 1, k % 4), a);
      bus(1, ctrl1_addr, c1((k / 4) % 4, k / 16, 0), a);
      bus(1, irq_status_addr, 7, a);
      level <= 4'hF ^ (4'h1 << (k % 4));
      repeat (8) @(posedge pclk);
      bus(0, irq_status_addr, 0, a);
      check(32'(a[cap_bit]), 0);
      level <= 4'hF;
      repeat (8) @(posedge pclk);
      bus(0, irq_status_addr, 0, a);
      check(32'(a[cap_bit]), 32'(k / 16 == 1 && (k / 4) % 2 == 1));
      bus(1, irq_status_addr, 7, a);
      level <= 4'hF ^ (4'h1 << (k % 4));
      repeat (8) @(posedge pclk);
      bus(0, irq_status_addr, 0, a);
      check(32'(a[cap_bit]), 32'(k / 16 == 1 && (k / 8) % 2 == 1));
      level <= 4'h0;
    end
    // Glitch filter: bypass takes a one-cycle pulse; with filter on, short pulses refused, long ones taken
    bus(1, ctrl0_addr, c0(1, 1, 1, 0), a);
    for (int k = 0; k < 9; k++) begin
      bus(1, ctrl1_addr, c1(1, 1, ft[k][0]), a);
      bus(1, irq_status_addr, 7, a);
      level <= 4'h1;
      repeat (ft[k][1]) @(posedge pclk);
      level <= 4'h0;
      repeat (40) @(posedge pclk);
      bus(0, irq_status_addr, 0, a);
      check(32'(a[cap_bit]), 32'(ft[k][2]));
    end
    // Two rising edges 64 cycles apart at half rate, then with auto-clear
    bus(1, ctrl0_addr, c0(0, 1, 1, 3), a);
    for (int m = 0; m < 2; m++) begin
      bus(1, ctrl1_addr, c1(1, 1, m * 2), a);
      level <= 4'h8;
      repeat (10) @(posedge pclk);
      bus(0, capture_value_low_byte_addr, 0, a);
      repeat (19) @(posedge pclk);
      level <= 4'h0;
      repeat (32 + m) @(posedge pclk); // Auto-clear eats the capture edge's tick
      level <= 4'h8;
      repeat (10) @(posedge pclk);
      bus(0, capture_value_low_byte_addr, 0, b);
      level <= 4'h0;
      if (m == 0) begin
        check(32'(8'(b - a)), 32);
      end else begin
        check(32'(b), 32);
        bus(0, capture_value_high_byte_addr, 0, a);
        check(32'(a), 0);
      end
    end
    // Compare match with auto-clear raises the masked interrupt
    bus(1, ctrl0_addr, 0, a);
    bus(1, compare_value_low_byte_addr, 32'h10, a);
    bus(1, compare_value_high_byte_addr, 0, a);
    bus(1, irq_status_addr, 7, a);
    bus(1, irq_mask_addr, 32'(1 << match_bit), a);
    bus(1, ctrl1_addr, c1(0, 0, 1), a);
    bus(1, ctrl0_addr, c0(0, 1, 1, 0), a);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n >= 29 && n <= 36), 1);
    for (int i = 0; i < 4; i++) begin
      repeat (7) @(posedge pclk);
      bus(0, counter_low_byte_addr, 0, a);
      check(32'(a <= 8'h10), 1);
    end
    bus(1, irq_mask_addr, 0, a);
    @(posedge pclk);
    check(32'(irq), 0);
    bus(1, ctrl0_addr, 0, a);
    bus(1, irq_mask_addr, 7, a);
    bus(1, irq_status_addr, 7, a);
    bus(0, irq_status_addr, 0, a);
    check(32'(a), 0);
    check(32'(irq), 0);
    // Overflow of the 12-bit counter after 4096 half-rate ticks
    bus(1, ctrl1_addr, 0, a);
    bus(1, irq_mask_addr, 32'(1 << ovf_bit), a);
    bus(1, ctrl0_addr, c0(0, 1, 1, 0), a);
    n = 0;
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n >= 8180 && n <= 8200), 1);
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule // capture_compare_timer_tb
`default_nettype wire
